//--- rtl/atr_readout.sv
// Behaviour
// - Ambient word is 16 bits, 13-bit two's complement temperature.
// - Reading is snapshot per read so conversions never disturb it.
// - Each converter result loads the word in one parallel update.
// - Bit 15 set when reading >= critical limit, else clear.
// - Bit 14 set when reading > upper limit, else clear.
// - Bit 13 set when reading < lower limit, else clear.
// - Bit 12 is the sign: one below zero degrees.
// - Flags ignore all alert configuration settings.
// - Low reading bits forced to zero per selected resolution.
// - Bit 11 weighs 2^7 degrees, bit 0 weighs 2^-4 degrees.
// - Upper byte first, then lower; host acks, nacks, stops.
// - Pointer 0x05 selects ambient word, zero after reset.
// - Pointer 0x06 selects the fixed read-only maker word.
// - Reading updates only outside low-power mode; bus stays active.
`timescale 1ns/100ps
module atr_readout #(
  parameter logic [6:0]  SLAVE_ADDR = atr_pkg::SLAVE_ADDR_DEFAULT,
  parameter logic [15:0] MAKER_ID   = atr_pkg::MAKER_ID_DEFAULT   // arbitrary value
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Two-wire bus pins
  input  wire logic                         sclIn,
  input  wire logic                         sdaIn,
  output logic                              sdaOut,
  output logic                              sdaOe,
  // Converter result and surrounding settings
  input  wire logic [atr_pkg::TEMP_W-1:0]   convResult,
  input  wire logic                         convValid,
  input  wire logic [atr_pkg::TEMP_W-1:0]   critLimit,
  input  wire logic [atr_pkg::TEMP_W-1:0]   upperLimit,
  input  wire logic [atr_pkg::TEMP_W-1:0]   lowerLimit,
  input  wire logic [1:0]                   resolutionSel,
  input  wire logic                         lowPowerSelect,
  // Current ambient word
  output logic [atr_pkg::WORD_W-1:0]        ambientReading
);
  import atr_pkg::*;

  // Mask of data bits kept at a given resolution
  function automatic logic [TEMP_W-1:0] resMask(input logic [1:0] res);
    unique case (res)
      RES_HALF:    resMask = MASK_HALF;
      RES_QUARTER: resMask = MASK_QUARTER;
      RES_EIGHTH:  resMask = MASK_EIGHTH;
      default:     resMask = MASK_SIXTEENTH;
    endcase
  endfunction

  // Pick upper (sel=0) or lower (sel=1) byte of a word
  function automatic logic [BYTE_W-1:0] wordByte(input logic [WORD_W-1:0] w, input logic sel);
    wordByte = sel ? w[BYTE_W-1:0] : w[WORD_W-1:BYTE_W];
  endfunction

  logic                sclMeta;
  logic                sclSync;
  logic                sclPrev;
  logic                sdaMeta;
  logic                sdaSync;
  logic                sdaPrev;
  logic                sclRise;
  logic                sclFall;
  logic                startDet;
  logic                stopDet;
  atr_state_t          stateReg;
  logic [3:0]          bitCntReg;
  logic [BYTE_W-1:0]   shiftInReg;
  logic [BYTE_W-1:0]   shiftOutReg;
  logic                rwReg;
  logic                firstDataReg;
  logic                hostNackReg;
  logic                byteSelReg;
  logic [BYTE_W-1:0]   pointerReg;
  logic [WORD_W-1:0]   readWordReg;
  logic [WORD_W-1:0]   ambientReg;
  logic [TEMP_W-1:0]   maskedResult;
  logic [BYTE_W-1:0]   firstByte;
  logic [BYTE_W-1:0]   nextByte;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  // Previous levels for edge and condition detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
    end
  end

  // Clock edges and start/stop conditions on the bus
  assign sclRise  = sclSync & ~sclPrev;
  assign sclFall  = ~sclSync & sclPrev;
  assign startDet = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopDet  = sclSync & sclPrev & ~sdaPrev & sdaSync;

  assign maskedResult = convResult & resMask(resolutionSel);

  // Parallel load per conversion; held in low power
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ambientReg <= AMBIENT_RESET;
    end else if (convValid && !lowPowerSelect) begin
      // Flags follow the loaded reading; no alert settings used
      ambientReg[FLAG_CRIT_BIT]  <= $signed(maskedResult) >= $signed(critLimit);
      ambientReg[FLAG_UPPER_BIT] <= $signed(maskedResult) > $signed(upperLimit);
      ambientReg[FLAG_LOWER_BIT] <= $signed(maskedResult) < $signed(lowerLimit);
      // Two's complement data, sign at bit 12
      ambientReg[SIGN_BIT:0]     <= maskedResult;
    end
  end

  assign ambientReading = ambientReg;

  // Bytes to send at the start of a read and after each host ack
  assign firstByte = wordByte(readWordReg, 1'b0);
  assign nextByte  = wordByte(readWordReg, byteSelReg);

  // Serial slave: address, pointer write, two-byte read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg     <= ST_IDLE;
      bitCntReg    <= '0;
      shiftInReg   <= '0;
      shiftOutReg  <= '0;
      rwReg        <= 1'b0;
      firstDataReg <= 1'b0;
      hostNackReg  <= 1'b0;
      byteSelReg   <= 1'b0;
      pointerReg   <= '0;
      readWordReg  <= '0;
      sdaOe        <= 1'b0;
    end else if (startDet) begin
      // Start or repeated start restarts address capture
      stateReg  <= ST_ADDR;
      bitCntReg <= '0;
      sdaOe     <= 1'b0;
    end else if (stopDet) begin
      stateReg <= ST_IDLE;
      sdaOe    <= 1'b0;
    end else begin
      unique case (stateReg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (sclRise) begin
            shiftInReg <= {shiftInReg[BYTE_W-2:0], sdaSync};
            bitCntReg  <= bitCntReg + 4'h1;
          end else if (sclFall && bitCntReg == BITS_PER_BYTE) begin
            if (shiftInReg[BYTE_W-1:1] == SLAVE_ADDR) begin
              sdaOe    <= 1'b1;
              rwReg    <= shiftInReg[0];
              stateReg <= ST_ADDR_ACK;
              // Snapshot so a conversion cannot tear the read
              if (pointerReg == PTR_AMBIENT) begin
                readWordReg <= ambientReg;
              end else if (pointerReg == PTR_MAKER) begin
                readWordReg <= MAKER_ID;
              end else begin
                readWordReg <= '0;
              end
            end else begin
              stateReg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (rwReg) begin
              sdaOe       <= ~firstByte[BYTE_W-1];
              shiftOutReg <= {firstByte[BYTE_W-2:0], 1'b0};
              bitCntReg   <= 4'h1;
              byteSelReg  <= 1'b1;
              stateReg    <= ST_RD_BYTE;
            end else begin
              sdaOe        <= 1'b0;
              bitCntReg    <= '0;
              firstDataReg <= 1'b1;
              stateReg     <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (sclRise) begin
            shiftInReg <= {shiftInReg[BYTE_W-2:0], sdaSync};
            bitCntReg  <= bitCntReg + 4'h1;
          end else if (sclFall && bitCntReg == BITS_PER_BYTE) begin
            // Every data byte acked; only the first sets the pointer
            sdaOe        <= 1'b1;
            firstDataReg <= 1'b0;
            if (firstDataReg) begin
              pointerReg <= shiftInReg;
            end
            stateReg <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (sclFall) begin
            sdaOe     <= 1'b0;
            bitCntReg <= '0;
            stateReg  <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (sclFall) begin
            if (bitCntReg == BITS_PER_BYTE) begin
              sdaOe    <= 1'b0;
              stateReg <= ST_RD_ACK;
            end else begin
              sdaOe       <= ~shiftOutReg[BYTE_W-1];
              shiftOutReg <= {shiftOutReg[BYTE_W-2:0], 1'b0};
              bitCntReg   <= bitCntReg + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (sclRise) begin
            hostNackReg <= sdaSync;
          end else if (sclFall) begin
            // Ack asks for the next byte, nack ends the read
            if (!hostNackReg) begin
              sdaOe       <= ~nextByte[BYTE_W-1];
              shiftOutReg <= {nextByte[BYTE_W-2:0], 1'b0};
              bitCntReg   <= 4'h1;
              byteSelReg  <= ~byteSelReg;
              stateReg    <= ST_RD_BYTE;
            end else begin
              stateReg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end
endmodule // atr_readout

//--- rtl/atr_pkg.sv
package atr_pkg;
  // Widths of the reading and of a serial byte
  localparam int TEMP_W = 13;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;

  // Register pointers decoded on the two-wire bus
  localparam logic [7:0]  PTR_AMBIENT = 8'h05;
  localparam logic [7:0]  PTR_MAKER   = 8'h06;

  // Reset value of the ambient reading word
  localparam logic [15:0] AMBIENT_RESET = 16'h0000;

  // Field positions in the ambient reading word
  localparam int FLAG_CRIT_BIT  = 15;
  localparam int FLAG_UPPER_BIT = 14;
  localparam int FLAG_LOWER_BIT = 13;
  localparam int SIGN_BIT       = 12;

  // Resolution select codes and the data bits each keeps
  localparam logic [1:0]  RES_HALF      = 2'h0;
  localparam logic [1:0]  RES_QUARTER   = 2'h1;
  localparam logic [1:0]  RES_EIGHTH    = 2'h2;
  localparam logic [1:0]  RES_SIXTEENTH = 2'h3;
  localparam logic [12:0] MASK_HALF      = 13'h1FF8;
  localparam logic [12:0] MASK_QUARTER   = 13'h1FFC;
  localparam logic [12:0] MASK_EIGHTH    = 13'h1FFE;
  localparam logic [12:0] MASK_SIXTEENTH = 13'h1FFF;

  // Bus address and maker word; the maker value is arbitrary
  localparam logic [6:0]  SLAVE_ADDR_DEFAULT = 7'h18;
  localparam logic [15:0] MAKER_ID_DEFAULT   = 16'h0A5C;

  // Bits in one serial byte
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // Serial protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } atr_state_t;
endpackage

//--- tb/atr_readout_properties.sv
`timescale 1ns/100ps
module atr_readout_checker (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // Bus pins
  input wire logic                       sclIn,
  input wire logic                       sdaIn,
  input wire logic                       sdaOut,
  input wire logic                       sdaOe,
  // Converter side and word
  input wire logic [atr_pkg::TEMP_W-1:0] convResult,
  input wire logic                       convValid,
  input wire logic [atr_pkg::TEMP_W-1:0] critLimit,
  input wire logic [atr_pkg::TEMP_W-1:0] upperLimit,
  input wire logic [atr_pkg::TEMP_W-1:0] lowerLimit,
  input wire logic [1:0]                 resolutionSel,
  input wire logic                       lowPowerSelect,
  input wire logic [atr_pkg::WORD_W-1:0] ambientReading
);
  import atr_pkg::*;
  logic [12:0] mres;
  logic        taken;
  // Result as it should land, masked before any compare
  always_comb begin
    case (resolutionSel)
      RES_HALF:    mres = convResult & MASK_HALF;
      RES_QUARTER: mres = convResult & MASK_QUARTER;
      RES_EIGHTH:  mres = convResult & MASK_EIGHTH;
      default:     mres = convResult & MASK_SIXTEENTH;
    endcase
  end
  // Shutdown blocks the load
  assign taken = convValid && !lowPowerSelect;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_data_load: assert property ($past(taken) |-> ambientReading[12:0] == $past(mres))
    else $error("data bits differ from masked result");
  a_crit_flag: assert property ($past(taken) |-> ambientReading[15] == ($signed($past(mres)) >= $signed($past(critLimit))))
    else $error("critical flag wrong");
  a_upper_flag: assert property ($past(taken) |-> ambientReading[14] == ($signed($past(mres)) > $signed($past(upperLimit))))
    else $error("upper flag wrong");
  a_lower_flag: assert property ($past(taken) |-> ambientReading[13] == ($signed($past(mres)) < $signed($past(lowerLimit))))
    else $error("lower flag wrong");
  a_word_hold: assert property (!$past(taken) |-> $stable(ambientReading))
    else $error("word changed without accepted result");
  a_reset_word: assert property ($fell(rst) |-> ambientReading == AMBIENT_RESET)
    else $error("word not zero after reset");
  a_drive_low: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  a_oe_on_fall: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn, 2))
    else $error("data pin changed outside clock low");
  a_oe_held: assert property ($rose(sclIn) && sdaOe |-> sdaOe [*4])
    else $error("data pin released while clock high");
endmodule // atr_readout_checker
bind atr_readout atr_readout_checker atr_readout_checker_inst (.core_clk(core_clk), .rst(rst), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .convResult(convResult), .convValid(convValid),
  .critLimit(critLimit), .upperLimit(upperLimit), .lowerLimit(lowerLimit), .resolutionSel(resolutionSel),
  .lowPowerSelect(lowPowerSelect), .ambientReading(ambientReading));

//--- tb/atr_host_model.sv
`timescale 1ns/100ps
module atr_host_model (
  // Bench clock and resolved wire
  input wire logic core_clk,
  input wire logic sdaWire,
  // Host drives; clock idles high
  output logic     scl,
  output logic     sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Quarter bit steps keep both phases at 8 cycles
  task automatic q(input int n);
    repeat (4 * n) @(posedge core_clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaLow = !b;
    q(1);
    scl = 1'b1;
    q(2);
    r = sdaWire;
    scl = 1'b0;
    q(1);
  endtask
  task automatic start();
    sdaLow = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sdaLow = 1'b1;
    q(2);
    scl = 1'b0;
    q(1);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    q(1);
    scl = 1'b1;
    q(2);
    sdaLow = 1'b0;
    q(2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ackIt, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(!ackIt, r);
  endtask
  task automatic xfer(input logic [6:0] adr, input logic [7:0] ptr, input logic rd,
                      input logic [15:0] wd, output logic [15:0] w, output logic [3:0] ak);
    start();
    wbyte({adr, 1'b0}, ak[3]);
    wbyte(ptr, ak[2]);
    if (rd) begin
      start();
      wbyte({adr, 1'b1}, ak[1]);
      rbyte(1'b1, w[15:8]);
      rbyte(1'b0, w[7:0]);
      ak[0] = 1'b0;
    end else begin
      wbyte(wd[15:8], ak[1]);
      wbyte(wd[7:0], ak[0]);
      w = 16'h0000;
    end
    stop();
  endtask
endmodule // atr_host_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import atr_pkg::*;
  localparam logic [6:0] ADDR = SLAVE_ADDR_DEFAULT;
  logic              core_clk, rst, scl, hostLow, sda, sdaOut, sdaOe, convValid, lowPowerSelect;
  logic [12:0]       convResult, critLimit, upperLimit, lowerLimit;
  logic [1:0]        resolutionSel;
  logic [15:0]       ambientReading;
  int                n_mismatch, checks_done;
  logic [12:0] masks [4] = '{MASK_HALF, MASK_QUARTER, MASK_EIGHTH, MASK_SIXTEENTH};
  logic [12:0] vals [7] = '{13'h0500, 13'h04FF, 13'h0190, 13'h0191, 13'h0000, 13'h1FFF, 13'h1000};
  // Open-drain wire with pull-up
  assign sda = (sdaOe ? sdaOut : 1'b1) & !hostLow;
  atr_readout atr_readout_inst (.core_clk(core_clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .convResult(convResult), .convValid(convValid), .critLimit(critLimit),
    .upperLimit(upperLimit), .lowerLimit(lowerLimit), .resolutionSel(resolutionSel),
    .lowPowerSelect(lowPowerSelect), .ambientReading(ambientReading));
  atr_host_model atr_host_model_inst (.core_clk(core_clk), .sdaWire(sda), .scl(scl), .sdaLow(hostLow));
  always #2 core_clk = ~core_clk;
  task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic access(input logic [6:0] adr, input logic [7:0] ptr, input logic rd,
                        input logic [15:0] wd, input logic [3:0] expAck, input logic [15:0] expData);
    logic [15:0] w;
    logic [3:0]  ak;
    atr_host_model_inst.xfer(adr, ptr, rd, wd, w, ak);
    compare({12'h000, ak}, {12'h000, expAck}, "acks");
    if (rd) compare(w, expData, "read word");
  endtask
  // Host conversion in sixteenths of a degree
  function automatic logic [15:0] toSixteenths(input logic [15:0] w);
    logic [7:0]  upperByte;
    logic [15:0] sum;
    upperByte = w[15:8] & 8'h1F;
    sum = {4'h0, upperByte[3:0], 8'h00} + {8'h00, w[7:0]};
    return upperByte[4] ? 16'h1000 - sum : sum;
  endfunction
  // Read the ambient word and check the host's degree figure
  task automatic readDegrees(input logic [15:0] expSixteenths);
    logic [15:0] w;
    logic [3:0]  ak;
    atr_host_model_inst.xfer(ADDR, PTR_AMBIENT, 1'b1, 16'h0000, w, ak);
    compare(toSixteenths(w), expSixteenths, "degrees");
  endtask
  task automatic conv(input logic [12:0] v);
    @(posedge core_clk);
    #1 convValid = 1'b1;
    convResult = v;
    @(posedge core_clk);
    #1 convValid = 1'b0;
  endtask
  // Expected word; flags follow the masked value
  function automatic logic [15:0] expWord(input logic [12:0] v);
    logic [12:0] m;
    m = v & masks[resolutionSel];
    return {$signed(m) >= $signed(critLimit), $signed(m) > $signed(upperLimit), $signed(m) < $signed(lowerLimit), m};
  endfunction
  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {core_clk, convValid, lowPowerSelect, n_mismatch, checks_done} = '0;
    rst = 1'b1;
    convResult = 13'h0000;
    resolutionSel = RES_QUARTER;
    {critLimit, upperLimit, lowerLimit} = {13'h0500, 13'h0190, 13'h0000};
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    compare(ambientReading, AMBIENT_RESET, "reset word");
    access(ADDR, PTR_AMBIENT, 1'b1, 16'h0000, 4'hE, AMBIENT_RESET);
    access(ADDR, PTR_MAKER, 1'b1, 16'h0000, 4'hE, MAKER_ID_DEFAULT);
    access(ADDR ^ 7'h01, PTR_AMBIENT, 1'b1, 16'h0000, 4'h0, 16'hFFFF);
    // Limit boundaries under every resolution
    for (int r = 0; r < 4; r++) begin
      resolutionSel = r[1:0];
      foreach (vals[i]) begin
        conv(vals[i]);
        compare(ambientReading, expWord(vals[i]), "ambient word");
      end
    end
    access(ADDR, PTR_AMBIENT, 1'b1, 16'h0000, 4'hE, expWord(13'h1000));
    lowPowerSelect = 1'b1;
    conv(13'h0123);
    access(ADDR, PTR_AMBIENT, 1'b1, 16'h0000, 4'hE, expWord(13'h1000));
    lowPowerSelect = 1'b0;
    access(ADDR, PTR_AMBIENT, 1'b0, 16'h1234, 4'hF, 16'h0000);
    access(ADDR, PTR_MAKER, 1'b0, 16'h1234, 4'hF, 16'h0000);
    access(ADDR, PTR_MAKER, 1'b1, 16'h0000, 4'hE, MAKER_ID_DEFAULT);
    // New result lands during the upper byte
    fork
      access(ADDR, PTR_AMBIENT, 1'b1, 16'h0000, 4'hE, expWord(13'h1000));
      begin
        repeat (560) @(posedge core_clk);
        conv(13'h0456);
      end
    join
    compare(ambientReading, expWord(13'h0456), "after snapshot");
    // Host figures: +25.25 and -1.25 degrees, as sixteenths
    conv(13'h0194);
    readDegrees(16'h0194);
    conv(13'h1FEC);
    readDegrees(16'h0014);
    tally_and_finish();
  end
endmodule // tb_top
